// >>> cmas_core.sv
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module cmas_core (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [6:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [7:0] avs_writedata,
   output logic [7:0] avs_readdata,
   output logic avs_waitrequest,
   input wire cmas_pkg::cmas_op_s op,
   input wire logic stk_rst_en,
   output logic [10:0] pm_addr,
   input wire logic [13:0] pm_data,
   output logic [10:0] prog_addr,
   output logic [7:0] alu_result,
   output logic stk_rst
);
   logic [15:0] fsr0_q, fsr1_q, addr;
   logic [4:0] bsr_q, st_q, cnt_q;
   logic [7:0] wreg_q, pclath_q, intcon_q, alu_q, rdata_q, rd_val;
   logic [14:0] pc_q;
   logic [7:0] ram_q [cmas_pkg::GPR_TOT];
   logic [7:0] com_q [cmas_pkg::COM_N];
   logic [14:0] stk_q [cmas_pkg::STK_DEPTH];
   logic ovf_q, unf_q, stk_rst_q;
   logic [10:0] pm_addr_q;
   cmas_pkg::cmas_rd_e rd_q;
   logic pm_sel, trad, core_hit, gpr_hit, com_hit, power_control_reg_hit;
   logic [6:0] off;
   logic [7:0] gidx;
   logic [3:0] cidx;
   logic wr_core, wr_ram, wr_com, wr_power_control_reg;
   logic push_ok, pop_ok, ovf_ev, unf_ev;
   logic [7:0] bb, alu_res;
   logic [8:0] sum9;
   logic [4:0] sum5;

   // indirect ports redirect the access through a pointer
   always_comb begin
      if (avs_address == cmas_pkg::OFF_INDF0) begin
         addr = fsr0_q;
      end else if (avs_address == cmas_pkg::OFF_INDF1) begin
         addr = fsr1_q;
      end else begin
         addr = {4'h0, bsr_q, avs_address};
      end
   end

   always_comb begin
      off = addr[6:0];
      pm_sel = addr[cmas_pkg::PM_BIT];
      trad = addr[15:12] == cmas_pkg::TRAD_TAG;
      core_hit = trad && (off < cmas_pkg::CORE_N);
      com_hit = trad && (off >= cmas_pkg::COM_LO);
      cidx = off[3:0];
      power_control_reg_hit = trad && (addr[11:7] == cmas_pkg::BANK_POWER_CONTROL_REG)
         && (off == cmas_pkg::OFF_POWER_CONTROL_REG);
      gidx = 8'h00;
      gpr_hit = 1'b0;
      if (trad && off >= cmas_pkg::GPR_LO && off < cmas_pkg::COM_LO
          && int'(addr[11:7]) < cmas_pkg::GPR_BANKS) begin
         gpr_hit = 1'b1;
         gidx = 8'(int'(addr[11:7]) * cmas_pkg::GPR_N
            + int'(off - cmas_pkg::GPR_LO));
      end else if (addr[15:13] == cmas_pkg::LIN_TAG
          && int'(addr - cmas_pkg::LIN_BASE) < cmas_pkg::GPR_TOT) begin
         gpr_hit = 1'b1;
         gidx = 8'(addr - cmas_pkg::LIN_BASE);
      end
   end

   // unmapped locations, including unimplemented special registers, read zero
   always_comb begin
      rd_val = 8'h00;
      if (core_hit) begin
         case (off)
            cmas_pkg::OFF_PCL: rd_val = pc_q[7:0];
            cmas_pkg::OFF_STATUS: rd_val = {3'h0, st_q};
            cmas_pkg::OFF_FSR0L: rd_val = fsr0_q[7:0];
            cmas_pkg::OFF_FSR0H: rd_val = fsr0_q[15:8];
            cmas_pkg::OFF_FSR1L: rd_val = fsr1_q[7:0];
            cmas_pkg::OFF_FSR1H: rd_val = fsr1_q[15:8];
            cmas_pkg::OFF_BSR: rd_val = {3'h0, bsr_q};
            cmas_pkg::OFF_WREG: rd_val = wreg_q;
            cmas_pkg::OFF_PCLATH: rd_val = pclath_q;
            cmas_pkg::OFF_INTCON: rd_val = intcon_q;
            default: rd_val = 8'h00;
         endcase
      end else if (gpr_hit) begin
         rd_val = ram_q[gidx];
      end else if (com_hit) begin
         rd_val = com_q[cidx];
      end else if (power_control_reg_hit) begin
         rd_val = {ovf_q, unf_q, 6'h00};
      end
   end

   // code space is read-only from the data side
   always_comb begin
      wr_core = avs_write && core_hit;
      wr_ram = avs_write && gpr_hit && !pm_sel;
      wr_com = avs_write && com_hit;
      wr_power_control_reg = avs_write && power_control_reg_hit;
   end

   // read sequencer; a code fetch adds one wait state
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_q <= cmas_pkg::RD_IDLE;
         rdata_q <= 8'h00;
         pm_addr_q <= 11'h000;
      end else begin
         case (rd_q)
            cmas_pkg::RD_IDLE: begin
               if (avs_read && pm_sel) begin
                  pm_addr_q <= addr[10:0];
                  rd_q <= cmas_pkg::RD_PM;
               end else if (avs_read) begin
                  rdata_q <= rd_val;
                  rd_q <= cmas_pkg::RD_DONE;
               end
            end
            cmas_pkg::RD_PM: begin
               rdata_q <= pm_data[7:0];
               rd_q <= cmas_pkg::RD_DONE;
            end
            cmas_pkg::RD_DONE: begin
               rd_q <= cmas_pkg::RD_IDLE;
            end
            default: rd_q <= cmas_pkg::RD_IDLE;
         endcase
      end
   end

   assign avs_waitrequest = avs_read && (rd_q != cmas_pkg::RD_DONE);
   assign avs_readdata = rdata_q;
   assign pm_addr = pm_addr_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         fsr0_q <= 16'h0000;
         fsr1_q <= 16'h0000;
         bsr_q <= 5'h00;
         wreg_q <= 8'h00;
         pclath_q <= 8'h00;
         intcon_q <= 8'h00;
      end else if (wr_core) begin
         case (off)
            cmas_pkg::OFF_FSR0L: fsr0_q[7:0] <= avs_writedata;
            cmas_pkg::OFF_FSR0H: fsr0_q[15:8] <= avs_writedata;
            cmas_pkg::OFF_FSR1L: fsr1_q[7:0] <= avs_writedata;
            cmas_pkg::OFF_FSR1H: fsr1_q[15:8] <= avs_writedata;
            cmas_pkg::OFF_BSR: bsr_q <= avs_writedata[4:0];
            cmas_pkg::OFF_WREG: wreg_q <= avs_writedata;
            cmas_pkg::OFF_PCLATH: pclath_q <= avs_writedata;
            cmas_pkg::OFF_INTCON: intcon_q <= avs_writedata;
            default: ;
         endcase
      end
   end

   // general RAM has no reset; software must initialise it
   always_ff @(posedge mclk) begin
      if (wr_ram) begin
         ram_q[gidx] <= avs_writedata;
      end
      if (wr_com) begin
         com_q[cidx] <= avs_writedata;
      end
   end

   always_comb begin
      push_ok = op.push && !op.pop && cnt_q != cmas_pkg::STK_FULL;
      pop_ok = op.pop && cnt_q != cmas_pkg::STK_EMPTY;
      ovf_ev = op.push && !op.pop && cnt_q == cmas_pkg::STK_FULL;
      unf_ev = op.pop && cnt_q == cmas_pkg::STK_EMPTY;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_q <= cmas_pkg::STK_EMPTY;
      end else if (push_ok) begin
         stk_q[cnt_q[3:0]] <= pc_q;
         cnt_q <= cnt_q + 5'h01;
      end else if (pop_ok) begin
         cnt_q <= cnt_q - 5'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pc_q <= 15'h0000;
      end else if (pop_ok) begin
         pc_q <= stk_q[4'(cnt_q - 5'h01)];
      end else if (op.pc_load) begin
         pc_q <= op.pc_next;
      end else if (wr_core && off == cmas_pkg::OFF_PCL) begin
         pc_q <= {pclath_q[6:0], avs_writedata};
      end
   end

   assign prog_addr = pc_q[10:0];

   // a new error wins over a software clear in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         ovf_q <= 1'b0;
         unf_q <= 1'b0;
         stk_rst_q <= 1'b0;
      end else begin
         ovf_q <= ovf_ev
            || (wr_power_control_reg ? avs_writedata[cmas_pkg::POWER_CONTROL_REG_OVF] : ovf_q);
         unf_q <= unf_ev
            || (wr_power_control_reg ? avs_writedata[cmas_pkg::POWER_CONTROL_REG_UNF] : unf_q);
         stk_rst_q <= stk_rst_en && (ovf_ev || unf_ev);
      end
   end

   assign stk_rst = stk_rst_q;

   always_comb begin
      bb = op.alu_sub ? ~op.alu_b : op.alu_b;
      sum9 = {1'b0, op.alu_a} + {1'b0, bb} + {8'h00, op.alu_sub};
      sum5 = {1'b0, op.alu_a[cmas_pkg::NIB-1:0]}
         + {1'b0, bb[cmas_pkg::NIB-1:0]} + {4'h0, op.alu_sub};
      alu_res = op.alu_arith ? sum9[7:0] : op.alu_a;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         alu_q <= 8'h00;
      end else if (op.alu_go) begin
         alu_q <= alu_res;
      end
   end

   assign alu_result = alu_q;

   // result flags take priority over a direct write to the same bits
   // one process owns the whole status word, so it has a single driver
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q <= cmas_pkg::STATUS_RST;
      end else begin
         if (op.alu_go) begin
            st_q[cmas_pkg::ST_Z] <= alu_res == 8'h00;
            if (op.alu_arith) begin
               st_q[cmas_pkg::ST_DC] <= sum5[cmas_pkg::NIB];
               st_q[cmas_pkg::ST_C] <= sum9[8];
            end
         end else if (wr_core && off == cmas_pkg::OFF_STATUS) begin
            // bus writes reach only the three result flags
            st_q[2:0] <= avs_writedata[2:0];
         end
         // only core events move timeout and power-down
         if (op.clear_watchdog_op) begin
            st_q[cmas_pkg::ST_PD] <= 1'b1;
         end else if (op.sleep) begin
            st_q[cmas_pkg::ST_PD] <= 1'b0;
         end
         if (op.wdt_to) begin
            st_q[cmas_pkg::ST_TO] <= 1'b0;
         end else if (op.clear_watchdog_op || op.sleep) begin
            st_q[cmas_pkg::ST_TO] <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   chk_stk_ovf_flag: assert property (
      ovf_ev |=> ovf_q && stk_rst == $past(stk_rst_en))
      else $error("overflow flag or reset pulse missing");
   chk_stk_unf_flag: assert property (
      unf_ev |=> unf_q && cnt_q == cmas_pkg::STK_EMPTY)
      else $error("underflow flag missing");
   chk_stk_depth_max: assert property (
      cnt_q == cmas_pkg::STK_FULL && op.push && !op.pop
      |=> cnt_q == cmas_pkg::STK_FULL)
      else $error("stack grew beyond sixteen");
   chk_pm_extra_wait: assert property (
      avs_read && pm_sel && rd_q == cmas_pkg::RD_IDLE
      |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
      else $error("code read wait states wrong");
   chk_pm_low_byte: assert property (
      rd_q == cmas_pkg::RD_PM |=> avs_readdata == $past(pm_data[7:0]))
      else $error("code read data not low byte");
   chk_pm_no_write: assert property (
      avs_write && pm_sel
      |-> !wr_ram && !wr_com && !wr_core && !wr_power_control_reg)
      else $error("write reached code space");
   chk_status_top_zero: assert property (
      avs_read && rd_q == cmas_pkg::RD_IDLE && core_hit
      && off == cmas_pkg::OFF_STATUS |=> avs_readdata[7:5] == 3'h0)
      else $error("status top bits not zero");
   chk_flags_alu_win: assert property (
      op.alu_go && op.alu_arith && wr_core && off == cmas_pkg::OFF_STATUS
      |=> st_q[cmas_pkg::ST_C] == $past(sum9[8])
      && st_q[cmas_pkg::ST_Z] == ($past(alu_res) == 8'h00))
      else $error("software write beat result flags");
   chk_to_pd_locked: assert property (
      !op.clear_watchdog_op && !op.sleep && !op.wdt_to |=> $stable(st_q[4:3]))
      else $error("timeout or power-down changed");
   chk_sleep_flags: assert property (
      op.sleep && !op.clear_watchdog_op && !op.wdt_to
      |=> st_q[cmas_pkg::ST_TO] && !st_q[cmas_pkg::ST_PD])
      else $error("sleep flags wrong");
   chk_unmapped_zero: assert property (
      avs_read && rd_q == cmas_pkg::RD_IDLE && !pm_sel && !core_hit
      && !gpr_hit && !com_hit && !power_control_reg_hit |=> avs_readdata == 8'h00)
      else $error("unmapped read not zero");

   cov_pm_read: cover property (rd_q == cmas_pkg::RD_PM);
   cov_stk_ovf: cover property (ovf_ev && stk_rst_en);
   cov_linear: cover property (
      avs_write && gpr_hit && addr[15:13] == cmas_pkg::LIN_TAG);
   cov_sleep: cover property (op.sleep);
   cov_code_write: cover property (avs_write && pm_sel);
endmodule

// >>> cmas_pkg.sv
package cmas_pkg;
   localparam int STK_DEPTH = 16;
   localparam int STK_W = 15;
   localparam int PC_W = 15;
   localparam int PM_AW = 11;
   localparam int PM_W = 14;
   localparam int BANK_W = 5;
   localparam int OFF_W = 7;
   localparam int GPR_N = 80;
   localparam int GPR_BANKS = 2;
   localparam int GPR_TOT = GPR_N * GPR_BANKS;
   localparam int COM_N = 16;
   localparam int NIB = 4;
   localparam int PM_BIT = 15;
   localparam logic [4:0] STK_FULL = 5'h10;
   localparam logic [4:0] STK_EMPTY = 5'h00;
   localparam logic [6:0] OFF_INDF0 = 7'h00;
   localparam logic [6:0] OFF_INDF1 = 7'h01;
   localparam logic [6:0] OFF_PCL = 7'h02;
   localparam logic [6:0] OFF_STATUS = 7'h03;
   localparam logic [6:0] OFF_FSR0L = 7'h04;
   localparam logic [6:0] OFF_FSR0H = 7'h05;
   localparam logic [6:0] OFF_FSR1L = 7'h06;
   localparam logic [6:0] OFF_FSR1H = 7'h07;
   localparam logic [6:0] OFF_BSR = 7'h08;
   localparam logic [6:0] OFF_WREG = 7'h09;
   localparam logic [6:0] OFF_PCLATH = 7'h0A;
   localparam logic [6:0] OFF_INTCON = 7'h0B;
   localparam logic [6:0] CORE_N = 7'h0C;
   localparam logic [6:0] GPR_LO = 7'h20;
   localparam logic [6:0] COM_LO = 7'h70;
   localparam logic [6:0] OFF_POWER_CONTROL_REG = 7'h16;
   localparam logic [4:0] BANK_POWER_CONTROL_REG = 5'h01;
   localparam logic [15:0] LIN_BASE = 16'h2000;
   localparam logic [2:0] LIN_TAG = 3'h1;
   localparam logic [3:0] TRAD_TAG = 4'h0;
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_PD = 3;
   localparam int ST_TO = 4;
   localparam logic [4:0] STATUS_RST = 5'h18;
   localparam int POWER_CONTROL_REG_OVF = 7;
   localparam int POWER_CONTROL_REG_UNF = 6;

   typedef enum logic [2:0] {
      RD_IDLE = 3'h1,
      RD_PM = 3'h2,
      RD_DONE = 3'h4
   } cmas_rd_e;

   typedef struct packed {
      logic push;
      logic pop;
      logic pc_load;
      logic [14:0] pc_next;
      logic alu_go;
      logic alu_arith;
      logic alu_sub;
      logic [7:0] alu_a;
      logic [7:0] alu_b;
      logic clear_watchdog_op;
      logic sleep;
      logic wdt_to;
   } cmas_op_s;
endpackage

// >>> cmas_pm_model.sv
`timescale 1ns/1ps
// code store behind the indirect fetch port, answers in the same cycle
// read only: there is no write port, so no indirect write can reach it
module cmas_pm_model (
   input wire logic [10:0] pm_addr,
   output logic [13:0] pm_data
);
   // upper bits differ from the low byte so a missing mask shows up
   assign pm_data = {pm_addr[5:0] ^ 6'h2A, pm_addr[10:3]};
endmodule

// >>> core_memory_addressing_status_test.sv
`timescale 1ns/1ps
module core_memory_addressing_status_test;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [6:0] avs_address = 7'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [7:0] avs_writedata = 8'h00;
   logic [7:0] avs_readdata;
   logic avs_waitrequest;
   cmas_pkg::cmas_op_s op = '0;
   logic stk_rst_en = 1'b0;
   logic [10:0] pm_addr;
   logic [13:0] pm_data;
   logic [10:0] prog_addr;
   logic [7:0] alu_result;
   logic stk_rst;
   int bad_count = 0;
   int tests_run = 0;
   logic [7:0] d;
   int w;
   logic s;

   always #4 mclk = ~mclk;

   cmas_core u_dut (
      .mclk(mclk),
      .rst(rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .op(op),
      .stk_rst_en(stk_rst_en),
      .pm_addr(pm_addr),
      .pm_data(pm_data),
      .prog_addr(prog_addr),
      .alu_result(alu_result),
      .stk_rst(stk_rst)
   );
   cmas_pm_model u_pm (.pm_addr(pm_addr), .pm_data(pm_data));

   task close_out;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task chk(input string n, input logic [15:0] seen, input logic [15:0] e);
      tests_run++;
      if (seen !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, seen);
      end
   endtask

   // the write lands at the first edge that sees waitrequest low
   task wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge mclk);
      avs_write <= 1'b1;
      avs_address <= a;
      avs_writedata <= v;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) @(posedge mclk);
      avs_write <= 1'b0;
   endtask

   // read data is taken at the edge that sees waitrequest low
   task rd(input logic [6:0] a, output logic [7:0] v, output int n);
      n = 0;
      @(posedge mclk);
      avs_read <= 1'b1;
      avs_address <= a;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) begin
         n++;
         @(posedge mclk);
      end
      v = avs_readdata;
      avs_read <= 1'b0;
   endtask

   task opx(input cmas_pkg::cmas_op_s o, output logic sr);
      @(posedge mclk);
      op <= o;
      @(posedge mclk);
      op <= '0;
      @(negedge mclk);
      sr = stk_rst;
   endtask

   task t_status;
      chk("prog_addr rst", 16'(prog_addr), 16'h0000);
      chk("alu_result rst", 16'(alu_result), 16'h0000);
      rd(cmas_pkg::OFF_STATUS, d, w);
      chk("status rst", 16'(d), 16'h0018);
      wr(cmas_pkg::OFF_STATUS, 8'hFF);
      rd(cmas_pkg::OFF_STATUS, d, w);
      chk("status ff", 16'(d), 16'h001F);
      wr(cmas_pkg::OFF_STATUS, 8'h00);
      rd(cmas_pkg::OFF_STATUS, d, w);
      chk("status 00", 16'(d), 16'h0018);
   endtask

   task alu_case(input logic [7:0] a, b, input logic sb, ar,
                 input logic [7:0] r, input logic [2:0] f);
      cmas_pkg::cmas_op_s o;
      o = '0;
      o.alu_go = 1'b1;
      o.alu_arith = ar;
      o.alu_sub = sb;
      o.alu_a = a;
      o.alu_b = b;
      opx(o, s);
      chk("alu_result", 16'(alu_result), 16'(r));
      rd(cmas_pkg::OFF_STATUS, d, w);
      chk("status flags", 16'(d[2:0]), 16'(f));
   endtask

   task t_alu;
      alu_case(8'h0F, 8'h01, 1'b0, 1'b1, 8'h10, 3'h2);
      alu_case(8'hFF, 8'h01, 1'b0, 1'b1, 8'h00, 3'h7);
      alu_case(8'h05, 8'h05, 1'b1, 1'b1, 8'h00, 3'h7);
      alu_case(8'h10, 8'h01, 1'b1, 1'b1, 8'h0F, 3'h1);
      alu_case(8'h00, 8'h01, 1'b1, 1'b1, 8'hFF, 3'h0);
      alu_case(8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 3'h4);
   endtask

   // bus write of status arrives on the same edge as a flag update, which wins
   task t_override;
      cmas_pkg::cmas_op_s o;
      o = '0;
      o.alu_go = 1'b1;
      o.alu_arith = 1'b1;
      o.alu_a = 8'h0F;
      o.alu_b = 8'h01;
      @(posedge mclk);
      op <= o;
      avs_write <= 1'b1;
      avs_address <= cmas_pkg::OFF_STATUS;
      avs_writedata <= 8'h05;
      @(posedge mclk);
      chk("write wait", 16'(avs_waitrequest), 16'h0000);
      op <= '0;
      avs_write <= 1'b0;
      rd(cmas_pkg::OFF_STATUS, d, w);
      chk("status override", 16'(d), 16'h001A);
   endtask

   task ev(input int k, input logic [1:0] e);
      cmas_pkg::cmas_op_s o;
      o = '0;
      o.sleep = (k == 0);
      o.wdt_to = (k == 1);
      o.clear_watchdog_op = (k == 2);
      opx(o, s);
      rd(cmas_pkg::OFF_STATUS, d, w);
      chk("timeout powerdown", 16'(d[4:3]), 16'(e));
   endtask

   task t_wdt;
      ev(0, 2'h2);
      ev(1, 2'h0);
      ev(2, 2'h3);
      ev(1, 2'h1);
      ev(0, 2'h2);
   endtask

   task t_banks;
      wr(cmas_pkg::OFF_BSR, 8'h01);
      wr(7'h20, 8'hA5);
      wr(cmas_pkg::OFF_BSR, 8'h00);
      wr(7'h20, 8'h5A);
      wr(7'h70, 8'hC3);
      wr(cmas_pkg::OFF_WREG, 8'h96);
      rd(7'h20, d, w);
      chk("bank0 ram", 16'(d), 16'h005A);
      chk("read waits", 16'(w), 16'h0001);
      wr(cmas_pkg::OFF_BSR, 8'h1F);
      rd(cmas_pkg::OFF_WREG, d, w);
      chk("core in bank31", 16'(d), 16'h0096);
      rd(cmas_pkg::OFF_BSR, d, w);
      chk("bank select", 16'(d), 16'h001F);
      rd(7'h20, d, w);
      chk("unimpl ram", 16'(d), 16'h0000);
      rd(7'h70, d, w);
      chk("common ram", 16'(d), 16'h00C3);
      rd(7'h0C, d, w);
      chk("unimpl special", 16'(d), 16'h0000);
      wr(cmas_pkg::OFF_BSR, 8'h01);
      rd(7'h20, d, w);
      chk("bank1 ram", 16'(d), 16'h00A5);
   endtask

   task t_indirect;
      wr(cmas_pkg::OFF_FSR0H, 8'h20);
      wr(cmas_pkg::OFF_FSR0L, 8'h50);
      rd(cmas_pkg::OFF_INDF0, d, w);
      chk("linear read", 16'(d), 16'h00A5);
      wr(cmas_pkg::OFF_FSR0L, 8'h51);
      wr(cmas_pkg::OFF_INDF0, 8'h3C);
      rd(7'h21, d, w);
      chk("linear write", 16'(d), 16'h003C);
      wr(cmas_pkg::OFF_FSR1H, 8'h00);
      wr(cmas_pkg::OFF_FSR1L, 8'h70);
      rd(cmas_pkg::OFF_INDF1, d, w);
      chk("pointer1 common", 16'(d), 16'h00C3);
      wr(cmas_pkg::OFF_FSR1H, 8'h8F);
      wr(cmas_pkg::OFF_FSR1L, 8'h23);
      rd(cmas_pkg::OFF_INDF1, d, w);
      chk("code read", 16'(d), 16'(11'h723 >> 3));
      chk("code waits", 16'(w), 16'h0002);
      wr(cmas_pkg::OFF_INDF1, 8'h00);
      rd(cmas_pkg::OFF_INDF1, d, w);
      chk("code unwritten", 16'(d), 16'(11'h723 >> 3));
   endtask

   task t_stack;
      cmas_pkg::cmas_op_s o;
      logic [14:0] v;
      stk_rst_en <= 1'b1;
      for (int i = 0; i <= 16; i++) begin
         v = 15'(i * 291 + 2065);
         o = '0;
         o.pc_load = 1'b1;
         o.pc_next = v;
         opx(o, s);
         chk("prog_addr", 16'(prog_addr), 16'(v[10:0]));
         o = '0;
         o.push = 1'b1;
         opx(o, s);
         chk("overflow reset", 16'(s), 16'(i == 16));
      end
      rd(cmas_pkg::OFF_POWER_CONTROL_REG, d, w);
      chk("overflow flag", 16'(d[7:6]), 16'h0002);
      wr(cmas_pkg::OFF_POWER_CONTROL_REG, 8'h00);
      stk_rst_en <= 1'b0;
      for (int i = 15; i >= -1; i--) begin
         o = '0;
         o.pop = 1'b1;
         opx(o, s);
         v = 15'(i * 291 + 2065);
         if (i >= 0)
            chk("pop order", 16'(prog_addr), 16'(v[10:0]));
      end
      chk("reset disabled", 16'(s), 16'h0000);
      rd(cmas_pkg::OFF_POWER_CONTROL_REG, d, w);
      chk("underflow flag", 16'(d[7:6]), 16'h0001);
   endtask

   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      t_status;
      t_alu;
      t_override;
      t_wdt;
      t_banks;
      t_indirect;
      t_stack;
      close_out;
   end

   // all scenarios take a few hundred cycles
   initial begin
      #200000;
      bad_count++;
      close_out;
   end
endmodule
